// file: core/afc_feature_regs.sv
// Behaviour
// R1: host sets exactly one interface select bit
// R2: no data updates while selects all zero
// R3: host writes zero to feature low bits
// R4: freeze bit stops fifo on motion event
// R5: tripped detector ignores events until cleared; code ignores them until rearmed per R6/R7
// R6: rearm off: detector rearms leaving wake mode
// R7: rearm on: clearing flag rearms detector
// R8: three-wire bit picks three-wire serial
// R9: two-wire select disables serial peripheral link
// R10: serial select disables two-wire link
// R11: no select keeps power-up interface type
// R12: wrap off: burst returns 0x02 after 0x07
// R13: wrap on: burst returns 0x02 after 0x09
// R14: wrap and burst same on every interface
// R15: burst off: one six-byte group per transaction
// R16: burst on: many groups, whole fifo
// R17: flags cleared by status read or write
// R18: stream drops oldest; else full refuses
// R19: burst pops next entry after each group
`timescale 1ns/1ps
`default_nettype none
module afc_feature_regs
    import afc_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire afc_access_type  acc,
    output logic                 acc_ready,
    output logic [7:0]           rd_byte,
    output logic                 rd_valid,
    input  wire logic            rd_ready,
    input  wire afc_sample_type  sample_in,
    input  wire logic            sample_valid,
    input  wire logic            fifo_enable,
    input  wire logic            wake_on_motion_mode,
    input  wire logic            motion_event,
    input  wire logic            powerup_is_spi,
    output logic                 i2c_active,
    output logic                 spi_active,
    output logic                 three_wire_active,
    output logic                 motion_wake_irq_flag,
    output logic                 capture_frozen,
    output logic [15:0]          x_axis_output,
    output logic [15:0]          y_axis_output,
    output logic [15:0]          z_axis_output
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (FIFO_DEPTH < 2) begin : g_bad
        $error("afc_feature_regs needs FIFO_DEPTH of at least 2");
    end

    localparam int CW = $clog2(FIFO_DEPTH+1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]        feature_1_ff;    // interface_and_motion_feature
    logic [7:0]        feature_2_ff;    // fifo_burst_feature
    logic [7:0]        addr_ff;         // burst address counter
    logic              strap_spi_ff;    // interface type caught after reset
    logic              strap_taken_ff;  // strap already caught
    logic              flag_ff;         // motion_wake_irq_flag
    logic              frozen_ff;       // fifo capture stopped
    afc_det_state_type det_ff;          // activity detector state
    afc_sample_type    out_ff;          // output data registers
    logic              loaded_ff;       // output regs hold an unread entry
    logic              hold_ff;         // no more pops this transaction

    logic [7:0]        nxt_addr;
    afc_det_state_type nxt_det;

    // ----------------------------------------------------------------
    // interface selection
    // ----------------------------------------------------------------
    wire sel_i2c   = feature_1_ff[F1_I2C_BIT];
    wire sel_spi   = feature_1_ff[F1_SPI_BIT] | feature_1_ff[F1_THREE_WIRE_BIT];
    // all three bits zero: registers work but no samples land
    wire any_sel   = sel_i2c | sel_spi;                                          // R2
    // one select forbids the other; with none, the strap decides
    assign i2c_active = !sel_spi && (sel_i2c || !strap_spi_ff);            // R10 R11
    assign spi_active = !sel_i2c && (sel_spi || strap_spi_ff);             // R9 R11
    assign three_wire_active = spi_active && feature_1_ff[F1_THREE_WIRE_BIT];    // R8

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    logic buf_in_ready;  // read byte buffer has room
    wire [7:0] cur_addr  = acc.start ? acc.addr : addr_ff;
    wire       rd_take   = acc.rd && buf_in_ready;
    wire       wr_take   = acc.wr;
    // wrap point is the same whatever link carried the access
    wire [7:0] wrap_end  = feature_2_ff[F2_WRAP_BIT] ? ADDR_STATUS_2 : ADDR_DATA_LAST; // R12 R13 R14
    wire       at_wrap   = (cur_addr == wrap_end);
    wire       group_end = rd_take && (cur_addr == ADDR_DATA_LAST);
    assign acc_ready = buf_in_ready;

    // next burst address
    always_comb begin
        nxt_addr = addr_ff;
        if (rd_take || wr_take) begin
            nxt_addr = at_wrap ? ADDR_DATA_FIRST : cur_addr + 8'h01;         // R12 R13
        end else if (acc.start) begin
            nxt_addr = acc.addr;
        end
    end

    // ----------------------------------------------------------------
    // flag clearing
    // ----------------------------------------------------------------
    wire wr_clear_sel = feature_2_ff[F2_CLEAR_WR_BIT] && sel_i2c;
    wire read_clears  = i2c_active && !wr_clear_sel;                             // R17
    wire write_clears = spi_active || wr_clear_sel;                              // R17
    wire flag_clear   = (rd_take && cur_addr == ADDR_STATUS_2 && read_clears)
                     || (wr_take && cur_addr == ADDR_STATUS_2 && write_clears);  // R17

    // ----------------------------------------------------------------
    // activity detector
    // ----------------------------------------------------------------
    wire trip = (det_ff == AFC_DET_ARMED) && wake_on_motion_mode && motion_event;

    always_comb begin
        nxt_det = det_ff;
        case (det_ff)
            AFC_DET_ARMED: begin
                if (trip) begin
                    nxt_det = AFC_DET_TRIPPED;
                end
            end
            AFC_DET_TRIPPED: begin
                // further events are ignored here until a rearm
                if (!wake_on_motion_mode) begin
                    nxt_det = AFC_DET_ARMED;                                     // R6
                end else if (flag_clear && feature_1_ff[F1_REARM_BIT]) begin
                    nxt_det = AFC_DET_ARMED;                                     // R7
                end
            end
            default: begin
                nxt_det = AFC_DET_ARMED;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sample fifo
    // ----------------------------------------------------------------
    afc_sample_type fifo_head;   // oldest sample
    logic           fifo_valid;  // fifo holds a sample
    logic           fifo_room;   // fifo can take a sample
    logic [CW-1:0]  fifo_count;  // samples held

    wire fifo_full  = (fifo_count == CW'(FIFO_DEPTH));
    wire fifo_empty = !fifo_valid;
    wire stream_on  = feature_2_ff[F2_STREAM_BIT] && fifo_enable;
    wire capture    = sample_valid && fifo_enable && any_sel && !frozen_ff;      // R2 R4
    // stream mode makes room by dropping the oldest entry
    wire drop_old   = capture && fifo_full && stream_on;                         // R18
    // outside stream mode a full fifo simply refuses the new sample
    wire push       = capture && (!fifo_full || stream_on);                      // R18
    // burst mode reloads on a group's last byte, in time for the next read
    wire load_regs  = fifo_enable && fifo_valid && !hold_ff
                   && (!loaded_ff || (group_end && feature_2_ff[F2_BURST_BIT]));  // R16 R19
    wire fifo_pop   = load_regs || drop_old;

    afc_buffer #(
        .WIDTH ($bits(afc_sample_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_sample_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (sample_in),
        .in_valid  (push),
        .in_ready  (fifo_room),
        .out_data  (fifo_head),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .count     (fifo_count)
    );

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    wire [7:0] status_1 = {fifo_valid && flag_ff, 1'b0, fifo_full, fifo_empty, 4'h0};
    wire [7:0] status_2 = {flag_ff, 7'h00};
    logic [7:0] rd_mux;  // byte at the current address

    always_comb begin
        case (cur_addr)
            8'h02:          rd_mux = out_ff.x[7:0];
            8'h03:          rd_mux = out_ff.x[15:8];
            8'h04:          rd_mux = out_ff.y[7:0];
            8'h05:          rd_mux = out_ff.y[15:8];
            8'h06:          rd_mux = out_ff.z[7:0];
            8'h07:          rd_mux = out_ff.z[15:8];
            ADDR_STATUS_1:  rd_mux = status_1;
            ADDR_STATUS_2:  rd_mux = status_2;
            ADDR_FEATURE_1: rd_mux = feature_1_ff & FEATURE_1_MASK;
            ADDR_FEATURE_2: rd_mux = feature_2_ff;
            default:        rd_mux = BYTE_ZERO;
        endcase
    end

    // two-entry buffer so a stalled receiver loses no byte
    afc_buffer #(
        .WIDTH (8),
        .DEPTH (READ_BUF_DEPTH)
    ) u_read_buf (
        .clk       (clk),
        .rst       (rst),
        .in_data   (rd_mux),
        .in_valid  (acc.rd),
        .in_ready  (buf_in_ready),
        .out_data  (rd_byte),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .count     ()
    );

    // ----------------------------------------------------------------
    // feature registers and address counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            feature_1_ff <= FEATURE_1_RESET;
            feature_2_ff <= FEATURE_2_RESET;
            addr_ff      <= BYTE_ZERO;
        end else begin
            addr_ff <= nxt_addr;
            // low bits are kept zero even if the host breaks the rule
            if (wr_take && cur_addr == ADDR_FEATURE_1) begin
                feature_1_ff <= acc.wdata & FEATURE_1_MASK;                      // R3
            end
            if (wr_take && cur_addr == ADDR_FEATURE_2) begin
                feature_2_ff <= acc.wdata;
            end
        end
    end

    // power-up interface type, caught once after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_spi_ff   <= 1'b0;
            strap_taken_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_spi_ff   <= powerup_is_spi;                                    // R11
            strap_taken_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // detector, flag and freeze
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            det_ff    <= AFC_DET_ARMED;
            flag_ff   <= 1'b0;
            frozen_ff <= 1'b0;
        end else begin
            det_ff <= nxt_det;                                                   // R5
            // a new trip in the clear cycle wins over the clear
            if (trip) begin
                flag_ff <= 1'b1;
            end else if (flag_clear) begin
                flag_ff <= 1'b0;                                                 // R17
            end
            if (trip && feature_1_ff[F1_FREEZE_BIT]) begin
                frozen_ff <= 1'b1;                                               // R4
            end else if (flag_clear || !wake_on_motion_mode) begin
                frozen_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // output data registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_ff    <= '0;
            loaded_ff <= 1'b0;
            hold_ff   <= 1'b0;
        end else begin
            if (load_regs) begin
                out_ff    <= fifo_head;                                          // R19
                loaded_ff <= 1'b1;
            end else if (!fifo_enable && sample_valid && any_sel) begin
                out_ff <= sample_in;                                             // R2
            end
            if (group_end && !load_regs) begin
                loaded_ff <= 1'b0;                                               // R16 R19
            end
            // without burst, one group per transaction keeps it atomic
            if (acc.start) begin
                hold_ff <= 1'b0;
            end else if (group_end && !feature_2_ff[F2_BURST_BIT]) begin
                hold_ff <= 1'b1;                                                 // R15
            end
        end
    end

    assign motion_wake_irq_flag = flag_ff;
    assign capture_frozen       = frozen_ff;
    assign x_axis_output        = out_ff.x;
    assign y_axis_output        = out_ff.y;
    assign z_axis_output        = out_ff.z;

endmodule
`default_nettype wire

// file: shared/afc_pkg.sv
`default_nettype none
package afc_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA_FIRST = 8'h02;  // x low byte, burst restart point
    localparam logic [7:0] ADDR_DATA_LAST  = 8'h07;  // z high byte, end of one sample group
    localparam logic [7:0] ADDR_STATUS_1   = 8'h08;  // fifo level flags
    localparam logic [7:0] ADDR_STATUS_2   = 8'h09;  // sticky event flags
    localparam logic [7:0] ADDR_FEATURE_1  = 8'h0D;  // interface_and_motion_feature
    localparam logic [7:0] ADDR_FEATURE_2  = 8'h0E;  // fifo_burst_feature

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int F1_FREEZE_BIT     = 3;  // capture freeze on motion event
    localparam int F1_REARM_BIT      = 4;  // detector_rearm_on_clear
    localparam int F1_THREE_WIRE_BIT = 5;  // three_wire_serial_select
    localparam int F1_I2C_BIT        = 6;  // two-wire interface select
    localparam int F1_SPI_BIT        = 7;  // four-wire serial select
    localparam int F2_WRAP_BIT       = 0;  // burst_wrap_select
    localparam int F2_BURST_BIT      = 1;  // fifo burst enable
    localparam int F2_CLEAR_WR_BIT   = 4;  // clear_by_write_select
    localparam int F2_STREAM_BIT     = 5;  // fifo stream mode
    localparam int S1_EMPTY_BIT      = 4;  // fifo empty level
    localparam int S1_FULL_BIT       = 5;  // fifo full level
    localparam int S1_PEND_BIT       = 7;  // event flag pending while the fifo holds a sample
    localparam int S2_MOTION_BIT     = 7;  // motion_wake_irq_flag

    localparam logic [7:0] FEATURE_1_RESET = 8'h00;
    localparam logic [7:0] FEATURE_2_RESET = 8'h00;
    localparam logic [7:0] FEATURE_1_MASK  = 8'hF8;  // low three bits always read zero
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    localparam int FIFO_DEPTH_DEFAULT = 32;  // sample entries
    localparam int READ_BUF_DEPTH     = 2;   // read byte buffer entries
    localparam int SAMPLE_WIDTH       = 16;  // bits per axis

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [SAMPLE_WIDTH-1:0] z;
        logic [SAMPLE_WIDTH-1:0] y;
        logic [SAMPLE_WIDTH-1:0] x;
    } afc_sample_type;

    typedef struct packed {
        logic       start;  // new transaction, addr valid
        logic       rd;     // request next read byte
        logic       wr;     // write byte in wdata
        logic [7:0] addr;   // start address
        logic [7:0] wdata;  // write data
    } afc_access_type;

    typedef enum logic [1:0] {
        AFC_DET_ARMED   = 2'b01,
        AFC_DET_TRIPPED = 2'b10
    } afc_det_state_type;

endpackage
`default_nettype wire

// file: core/afc_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module afc_buffer
    import afc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [WIDTH-1:0]           in_data,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      count
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("afc_buffer needs DEPTH of at least 2");
    end

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH-1);

    logic [WIDTH-1:0] mem_ff [DEPTH];  // entry storage
    logic [PW-1:0]    wr_ptr_ff;       // next write slot
    logic [PW-1:0]    rd_ptr_ff;       // oldest entry
    logic [CW-1:0]    count_ff;        // entries held

    wire full  = (count_ff == CW'(DEPTH));
    wire empty = (count_ff == '0);
    wire pop   = out_valid && out_ready;
    // a pop in the same cycle frees the slot, so a full buffer still flows
    wire push  = in_valid && in_ready;

    assign in_ready  = !full || out_ready;
    assign out_valid = !empty;
    assign out_data  = mem_ff[rd_ptr_ff];
    assign count     = count_ff;

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + CW'(push) - CW'(pop);
        end
    end

endmodule
`default_nettype wire

// file: tb/afc_feature_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module afc_feature_regs_chk
    import afc_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst,
    input wire afc_access_type acc,
    input wire logic           acc_ready,
    input wire logic [7:0]     rd_byte,
    input wire logic           rd_valid,
    input wire logic           rd_ready,
    input wire logic           wake_on_motion_mode,
    input wire logic           motion_event,
    input wire logic           i2c_active,
    input wire logic           spi_active,
    input wire logic           three_wire_active,
    input wire logic           motion_wake_irq_flag,
    input wire logic           capture_frozen
);
    // ----
    // link selection and read buffer
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_one_if; !(i2c_active && spi_active); endproperty
    a_one_if: assert property (p_one_if) else $error("two links on");
    property p_three; three_wire_active |-> !i2c_active; endproperty
    a_three: assert property (p_three) else $error("three wire with i2c");
    property p_rd_lat; acc.rd && acc_ready |=> rd_valid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read byte late");
    // stalled byte stands
    property p_stand; rd_valid && !rd_ready |=> rd_valid && $stable(rd_byte); endproperty
    a_stand: assert property (p_stand) else $error("byte dropped");
    property p_full; !acc_ready |-> rd_valid; endproperty
    a_full: assert property (p_full) else $error("refused while empty");
    // ----
    // motion detector
    // ----
    property p_flag_up;
        $rose(motion_wake_irq_flag) |-> $past(motion_event && wake_on_motion_mode);
    endproperty
    a_flag_up: assert property (p_flag_up) else $error("flag without event");
    property p_flag_hold; motion_wake_irq_flag && !acc.rd && !acc.wr && wake_on_motion_mode
        |=> motion_wake_irq_flag; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_frz; capture_frozen |-> motion_wake_irq_flag; endproperty
    a_frz: assert property (p_frz) else $error("frozen without flag");
    property p_frz_up; $rose(capture_frozen) |-> $past(motion_event); endproperty
    a_frz_up: assert property (p_frz_up) else $error("freeze off trip");
    c_trip: cover property ($rose(motion_wake_irq_flag));
    c_frz: cover property ($rose(capture_frozen));
    c_stall: cover property (!acc_ready);
endmodule
bind afc_feature_regs afc_feature_regs_chk u_chk (
    .clk(clk), .rst(rst), .acc(acc), .acc_ready(acc_ready), .rd_byte(rd_byte),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .wake_on_motion_mode(wake_on_motion_mode),
    .motion_event(motion_event), .i2c_active(i2c_active), .spi_active(spi_active),
    .three_wire_active(three_wire_active), .motion_wake_irq_flag(motion_wake_irq_flag),
    .capture_frozen(capture_frozen));
`default_nettype wire

// file: tb/afc_host.sv
`timescale 1ns/1ps
`default_nettype none
module afc_host
    import afc_pkg::*;
(
    input  wire logic       clk,
    output var afc_access_type acc,
    input  wire logic       acc_ready,
    input  wire logic [7:0] rd_byte,
    input  wire logic       rd_valid,
    output var logic        rd_ready
);
    initial acc = '0;
    initial rd_ready = 1'b0;
    // single write byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        acc <= '{1'b1, 1'b0, 1'b1, a, d};
        @(posedge clk);
        acc <= '0;
    endtask
    // burst read, sampled at negedge to avoid races
    task automatic rd(input logic [7:0] a, input int n, input int slow,
                      output logic [7:0] q[$]);
        int req = 0, t = 0;
        logic tk;
        q = {};
        @(posedge clk);
        acc <= '{1'b1, 1'b0, 1'b0, a, 8'h00};
        rd_ready <= 1'b0;
        while (q.size() < n) begin
            @(negedge clk);
            tk = acc.rd && acc_ready;
            if (rd_valid && rd_ready) q.push_back(rd_byte);
            @(posedge clk);
            req += int'(tk);
            t++;
            // stall first so the buffer fills
            acc <= '{1'b0, req < n, 1'b0, a, 8'h00};
            rd_ready <= (t > slow);
        end
    endtask
endmodule
`default_nettype wire

// file: tb/accel_feature_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module accel_feature_config_bench
    import afc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, acc_ready, rd_valid, rd_ready, sample_valid = 1'b0;
    logic fifo_enable = 1'b0, wake = 1'b0, motion_event = 1'b0, powerup_is_spi = 1'b0;
    logic i2c_active, spi_active, three_wire_active, flag, frozen;
    logic [7:0] rd_byte;
    logic [15:0] x_out, y_out, z_out;
    afc_access_type acc;
    afc_sample_type sample_in = '0;
    int failures = 0, samples_checked = 0;
    logic [7:0] q[$];
    always #25 clk = ~clk;
    afc_feature_regs u_dut (.clk(clk), .rst(rst), .acc(acc), .acc_ready(acc_ready),
        .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_ready(rd_ready), .sample_in(sample_in),
        .sample_valid(sample_valid), .fifo_enable(fifo_enable), .wake_on_motion_mode(wake),
        .motion_event(motion_event), .powerup_is_spi(powerup_is_spi),
        .i2c_active(i2c_active), .spi_active(spi_active),
        .three_wire_active(three_wire_active), .motion_wake_irq_flag(flag),
        .capture_frozen(frozen), .x_axis_output(x_out), .y_axis_output(y_out),
        .z_axis_output(z_out));
    afc_host u_host (.clk(clk), .acc(acc), .acc_ready(acc_ready), .rd_byte(rd_byte),
        .rd_valid(rd_valid), .rd_ready(rd_ready));
    // ----
    // helpers
    // ----
    task automatic check(input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic push(input logic [15:0] x, y, z);
        @(posedge clk);
        sample_in <= '{z, y, x};
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic ev;
        @(posedge clk);
        motion_event <= 1'b1;
        @(posedge clk);
        motion_event <= 1'b0;
        @(negedge clk);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        u_host.rd(ADDR_FEATURE_1, 2, 0, q);
        check(q[0], FEATURE_1_RESET);
        check(q[1], FEATURE_2_RESET);
        check(i2c_active, 1'b1);
        push(16'h1234, 16'h5678, 16'h9ABC);
        check(x_out | y_out | z_out, 16'h0000);
    endtask
    task automatic t_iface;
        logic [7:0] w[4] = '{8'h80, 8'h20, 8'h48, 8'h40};
        logic [2:0] e[4] = '{3'b010, 3'b011, 3'b100, 3'b100};
        for (int i = 0; i < 4; i++) begin
            u_host.wr(ADDR_FEATURE_1, w[i]);
            @(negedge clk);
            check({i2c_active, spi_active, three_wire_active}, e[i]);
            u_host.rd(ADDR_FEATURE_1, 1, 0, q);
            check(q[0], w[i] & FEATURE_1_MASK);
        end
    endtask
    task automatic t_wrap;
        logic [7:0] e[8] = '{8'h22, 8'h11, 8'h44, 8'h33, 8'h66, 8'h55, 8'h22, 8'h11};
        push(16'h1122, 16'h3344, 16'h5566);
        check(x_out, 16'h1122);
        u_host.wr(ADDR_FEATURE_2, 8'h00);
        u_host.rd(ADDR_DATA_FIRST, 8, 0, q);
        for (int i = 0; i < 8; i++) check(q[i], e[i]);
        u_host.wr(ADDR_FEATURE_2, 8'h01);
        u_host.rd(8'h06, 6, 4, q);
        check({q[1], q[0]}, 16'h5566);
        check(q[3], 8'h00);
        check({q[5], q[4]}, 16'h1122);
    endtask
    task automatic t_fifo;
        @(posedge clk);
        fifo_enable <= 1'b1;
        u_host.wr(ADDR_FEATURE_2, 8'h02);
        for (int i = 0; i < 3; i++) push(16'h0A00 + i, 16'h0B00 + i, 16'h0C00 + i);
        u_host.rd(ADDR_DATA_FIRST, 18, 0, q);
        for (int i = 0; i < 3; i++) begin
            check({q[6*i+1], q[6*i]}, 16'h0A00 + i);
            check({q[6*i+5], q[6*i+4]}, 16'h0C00 + i);
        end
        u_host.wr(ADDR_FEATURE_2, 8'h00);
        push(16'h0D00, 16'h0E00, 16'h0F00);
        push(16'h0D01, 16'h0E01, 16'h0F01);
        u_host.rd(ADDR_DATA_FIRST, 12, 0, q);
        check({q[1], q[0]}, 16'h0D00);
        check({q[7], q[6]}, 16'h0D00);
        fifo_enable <= 1'b0;
    endtask
    task automatic t_motion;
        u_host.wr(ADDR_FEATURE_1, 8'h48);
        wake <= 1'b1;
        ev();
        check({flag, frozen}, 2'b11);
        ev();
        check(flag, 1'b1);
        u_host.rd(ADDR_STATUS_2, 1, 0, q);
        check(q[0], 8'h80);
        @(negedge clk);
        check({flag, frozen}, 2'b00);
        ev();
        check(flag, 1'b0);
        @(posedge clk);
        wake <= 1'b0;
        @(posedge clk);
        wake <= 1'b1;
        ev();
        check(flag, 1'b1);
        u_host.wr(ADDR_FEATURE_1, 8'h50);
        u_host.rd(ADDR_STATUS_2, 1, 0, q);
        ev();
        check({flag, frozen}, 2'b10);
        u_host.wr(ADDR_FEATURE_1, 8'h90);
        u_host.wr(ADDR_STATUS_2, 8'h00);
        @(negedge clk);
        check(flag, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_iface();
        t_wrap();
        t_fifo();
        t_motion();
        summarize();
    end
    // watchdog, run needs under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
